// ### hdl/cmpc_pkg.sv
package cmpc_pkg;

	// Register word indices, bus byte address is four times the index; sleep is a byte address (printed offsets are not all multiples of four)
	localparam logic [2:0] CMPC_IDX_CTRL = 3'h0;
	localparam logic [2:0] CMPC_IDX_MUX = 3'h2;
	localparam logic [2:0] CMPC_IDX_DIV = 3'h4;
	localparam logic [2:0] CMPC_IDX_INTERRUPT_CONTROL = 3'h6;
	localparam logic [2:0] CMPC_IDX_STATUS = 3'h7;
	localparam logic [7:0] CMPC_ADDR_SLEEP = 8'h20;

	// Control register fields
	localparam int CMPC_CTRL_RUN_ASLEEP = 7;
	localparam int CMPC_CTRL_PAD_EN = 6;
	localparam int CMPC_CTRL_EDGE_HI = 5;
	localparam int CMPC_CTRL_EDGE_LO = 4;
	localparam int CMPC_CTRL_LOWCUR = 3;
	localparam int CMPC_CTRL_HYS_HI = 2;
	localparam int CMPC_CTRL_HYS_LO = 1;
	localparam int CMPC_CTRL_ENABLE = 0;

	// Input-select register fields
	localparam int CMPC_MUX_INVERT = 7;
	localparam int CMPC_MUX_POS_HI = 4;
	localparam int CMPC_MUX_POS_LO = 3;
	localparam int CMPC_MUX_NEG_HI = 1;
	localparam int CMPC_MUX_NEG_LO = 0;
	localparam logic [7:0] CMPC_MUX_MASK = 8'h9b;

	// Status fields
	localparam int CMPC_STAT_STATE = 4;
	localparam int CMPC_STAT_FLAG = 0;

	// Reset values
	localparam logic [7:0] CMPC_CTRL_RST = 8'h00;
	localparam logic [7:0] CMPC_MUX_RST = 8'h00;
	localparam logic [7:0] CMPC_DIV_RST = 8'hff;
	localparam logic [7:0] CMPC_INTERRUPT_CONTROL_RST = 8'h00;
	localparam logic [1:0] CMPC_SLEEP_RST = 2'h0;

	// Edge modes
	localparam logic [1:0] CMPC_EDGE_ANY = 2'h0;
	localparam logic [1:0] CMPC_EDGE_FALL = 2'h2;
	localparam logic [1:0] CMPC_EDGE_RISE = 2'h3;

	// Sleep modes
	localparam logic [1:0] CMPC_SLEEP_ACTIVE = 2'h0;
	localparam logic [1:0] CMPC_SLEEP_STANDBY = 2'h2;
	localparam logic [1:0] CMPC_SLEEP_POWERDOWN = 2'h3;

	// AHB encodings
	localparam logic [1:0] CMPC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] CMPC_HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		CMPC_ST_RUN = 2'b01,
		CMPC_ST_HALT = 2'b10
	} cmpc_state_type;

endpackage

// ### hdl/cmpc_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Keep-running-asleep bit keeps comparator working in standby; clear halts it.
// - With the clock stopped in standby, flag and status bits do not update.
// - Pad enable bit routes the comparator output to its pin.
// - Edge field: 0 any edge, 1 reserved, 2 falling, 3 rising.
// - Control bit 3 drives the analog low-current mode.
// - Hysteresis field passed to analog core: none, small, medium, large.
// - Control bit 0 enables the comparator.
// - Invert bit inverts the result before every user of it.
// - Positive select picks positive pin 0 to 3 by value.
// - Negative select picks negative pins 0 to 2, or divider reference at 3.
// - Eight-bit divider value, reset 0xff, sets reference level over 256.
// - Interrupt-control bit 0 enables the compare interrupt.
// - Status bit 4 shows the output after a three-cycle synchronizer.
// - Status bit 0 is the flag; writing one clears, zero leaves it.
// - Flag sets when the output toggles in the selected direction.
// - Interrupt request is high while flag and its enable are set.
// - Output level goes to event network registered, after the synchronizer; no event inputs.
// - Power-down sleep disables comparator and pad output regardless.
module cmpc_top
	import cmpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic i_cmp_raw,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_cmp_enable,
	output logic o_low_current_select,
	output logic [1:0] o_hysteresis_level,
	output logic [1:0] o_positive_input_select,
	output logic [1:0] o_negative_input_select,
	output logic [7:0] o_divider_reference_level,
	output logic o_invert,
	output logic o_output_pad_enable,
	output logic o_event_level,
	output logic o_irq
);

	logic [7:0] ctrl_q;
	logic [7:0] mux_q;
	logic [7:0] div_q;
	logic [7:0] interrupt_control_q;
	logic [1:0] sleep_q;
	logic flag_q;
	logic [2:0] sync_q;
	logic state_prev_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;
	cmpc_state_type st_q;
	cmpc_state_type st_d;

	function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] lane);
		byte_of = word[8*lane +: 8];
	endfunction

	function automatic logic reg_hit(input logic [7:0] a, input logic [2:0] index);
		reg_hit = (a == {3'h0, index, 2'h0});
	endfunction

	// Reserved edge code matches nothing, so software cannot get stray flags
	function automatic logic edge_match(input logic [1:0] mode, input logic rise, input logic fall);
		case (mode)
			CMPC_EDGE_ANY: edge_match = rise || fall;
			CMPC_EDGE_FALL: edge_match = fall;
			CMPC_EDGE_RISE: edge_match = rise;
			default: edge_match = 1'b0;
		endcase
	endfunction

	// Bus decode: one-cycle address phase, zero wait states
	wire take = i_hsel && i_hready && (i_htrans == CMPC_HTRANS_NONSEQ);
	wire take_rd = take && !i_hwrite;
	wire take_wr = take && i_hwrite;
	wire [7:0] addr = i_haddr[7:0];
	wire [2:0] idx = addr[4:2];
	wire in_reg_space = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
	wire [7:0] wdata = byte_of(i_hwdata, 2'h0);
	wire wr_ctrl = wr_pend_q && reg_hit(wr_addr_q, CMPC_IDX_CTRL);
	wire wr_mux = wr_pend_q && reg_hit(wr_addr_q, CMPC_IDX_MUX);
	wire wr_div = wr_pend_q && reg_hit(wr_addr_q, CMPC_IDX_DIV);
	wire wr_int = wr_pend_q && reg_hit(wr_addr_q, CMPC_IDX_INTERRUPT_CONTROL);
	wire wr_stat = wr_pend_q && reg_hit(wr_addr_q, CMPC_IDX_STATUS);
	wire wr_sleep = wr_pend_q && (wr_addr_q == CMPC_ADDR_SLEEP);

	// Sleep handling: standby halts unless kept running, power-down always halts
	wire in_standby = (sleep_q == CMPC_SLEEP_STANDBY);
	wire in_powerdown = (sleep_q == CMPC_SLEEP_POWERDOWN);
	wire halt_cond = in_powerdown || (in_standby && !ctrl_q[CMPC_CTRL_RUN_ASLEEP]);
	wire running = (st_q == CMPC_ST_RUN);
	// In standby the peripheral clock is stopped, so status never moves there
	wire status_live = running && !in_standby;

	always_comb begin
		unique case (st_q)
			CMPC_ST_RUN: st_d = halt_cond ? CMPC_ST_HALT : CMPC_ST_RUN;
			CMPC_ST_HALT: st_d = halt_cond ? CMPC_ST_HALT : CMPC_ST_RUN;
			default: st_d = CMPC_ST_HALT;
		endcase
	end

	// Output after inversion, seen through the synchronizer
	wire cmp_state = sync_q[2] ^ mux_q[CMPC_MUX_INVERT];
	wire cmp_rise = cmp_state && !state_prev_q;
	wire cmp_fall = !cmp_state && state_prev_q;
	wire [1:0] edge_mode = ctrl_q[CMPC_CTRL_EDGE_HI:CMPC_CTRL_EDGE_LO];
	wire edge_hit = edge_match(edge_mode, cmp_rise, cmp_fall);
	wire flag_set = edge_hit && status_live && ctrl_q[CMPC_CTRL_ENABLE];
	wire flag_clr = wr_stat && wdata[CMPC_STAT_FLAG];

	wire [7:0] status_byte = {3'h0, cmp_state, 3'h0, flag_q};
	wire [7:0] rd_byte = (idx == CMPC_IDX_CTRL[2:0]) ? ctrl_q :
		(idx == CMPC_IDX_MUX[2:0]) ? mux_q :
		(idx == CMPC_IDX_DIV[2:0]) ? div_q :
		(idx == CMPC_IDX_INTERRUPT_CONTROL[2:0]) ? interrupt_control_q :
		(idx == CMPC_IDX_STATUS[2:0]) ? status_byte : 8'h00;
	wire [31:0] rd_word = (addr == CMPC_ADDR_SLEEP) ? {30'h0, sleep_q} :
		in_reg_space ? {24'h0, rd_byte} : 32'h0;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= take_wr;
		end
	end

	// Address is held through the data phase, so the copy is always current
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_addr_q <= 8'h00;
		end else begin
			wr_addr_q <= addr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hrdata_q <= 32'h0;
		end else if (take_rd) begin
			hrdata_q <= rd_word;
		end
	end

	// One block per register keeps each write path easy to follow
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= CMPC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata;
		end
	end

	// Reserved bits are masked so they always read zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mux_q <= CMPC_MUX_RST;
		end else if (wr_mux) begin
			mux_q <= wdata & CMPC_MUX_MASK;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_q <= CMPC_DIV_RST;
		end else if (wr_div) begin
			div_q <= wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			interrupt_control_q <= CMPC_INTERRUPT_CONTROL_RST;
		end else if (wr_int) begin
			interrupt_control_q <= {7'h0, wdata[0]};
		end
	end

	// Stand-in for the system sleep controller
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sleep_q <= CMPC_SLEEP_RST;
		end else if (wr_sleep) begin
			sleep_q <= wdata[1:0];
		end
	end

	// Raw pin passes three flops before anything reads it; inversion comes after
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_q <= 3'h0;
		end else if (status_live) begin
			sync_q <= {sync_q[1:0], i_cmp_raw};
		end
	end

	// Previous state freezes with the status, so waking makes no false edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_prev_q <= 1'b0;
		end else if (status_live) begin
			state_prev_q <= cmp_state;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= CMPC_ST_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// Named fields of the control, input-select and interrupt registers
	wire pad_en = ctrl_q[CMPC_CTRL_PAD_EN];
	wire low_cur = ctrl_q[CMPC_CTRL_LOWCUR];
	wire [1:0] hys_field = ctrl_q[CMPC_CTRL_HYS_HI:CMPC_CTRL_HYS_LO];
	wire cmp_on = ctrl_q[CMPC_CTRL_ENABLE];
	wire invert_on = mux_q[CMPC_MUX_INVERT];
	wire [1:0] pos_field = mux_q[CMPC_MUX_POS_HI:CMPC_MUX_POS_LO];
	wire [1:0] neg_field = mux_q[CMPC_MUX_NEG_HI:CMPC_MUX_NEG_LO];
	wire irq_on = interrupt_control_q[0];

	// Next state used so the core is cut on the same edge the halt state lands, one edge after the sleep write lands
	wire active_en = cmp_on && (st_d == CMPC_ST_RUN);

	// Request follows the flag's next value, so the registered request moves with the flag register
	wire flag_next = flag_set || (flag_q && !flag_clr);
	wire irq_next = flag_next && irq_on;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cmp_enable <= 1'b0;
		end else begin
			o_cmp_enable <= active_en;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_low_current_select <= 1'b0;
		end else begin
			o_low_current_select <= low_cur;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hysteresis_level <= 2'h0;
		end else begin
			o_hysteresis_level <= hys_field;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_positive_input_select <= 2'h0;
		end else begin
			o_positive_input_select <= pos_field;
		end
	end

	// Code three selects the divider reference in the analog core
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_negative_input_select <= 2'h0;
		end else begin
			o_negative_input_select <= neg_field;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_divider_reference_level <= CMPC_DIV_RST;
		end else begin
			o_divider_reference_level <= div_q;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_invert <= 1'b0;
		end else begin
			o_invert <= invert_on;
		end
	end

	// Pad is dropped together with the core, whatever the pad bit says
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_output_pad_enable <= 1'b0;
		end else begin
			o_output_pad_enable <= active_en && pad_en;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_next;
		end
	end

	// Event level is registered from the synchronized output; no event inputs exist
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_event_level <= 1'b0;
		end else begin
			o_event_level <= cmp_state && cmp_on;
		end
	end

	// Zero wait states: every transfer completes in its data phase
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hreadyout <= 1'b1;
		end else begin
			o_hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hresp <= 1'b0;
		end else begin
			o_hresp <= 1'b0;
		end
	end

	assign o_hrdata = hrdata_q;

endmodule // cmpc_top

// ### verif/cmpc_props.sv
`timescale 1ns/1ps
module cmpc_props
	import cmpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic i_hready,
	input wire logic i_hwrite,
	input wire logic [1:0] i_htrans,
	input wire logic [31:0] i_haddr,
	input wire logic [31:0] i_hwdata,
	input wire logic [1:0] o_hysteresis_level,
	input wire logic o_low_current_select,
	input wire logic [1:0] o_positive_input_select,
	input wire logic [1:0] o_negative_input_select,
	input wire logic o_invert,
	input wire logic [7:0] o_divider_reference_level,
	input wire logic o_output_pad_enable,
	input wire logic o_cmp_enable,
	input wire logic o_irq
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	wire wr = i_hsel && i_hready && i_htrans == CMPC_HTRANS_NONSEQ && i_hwrite;
	wire wc = wr && i_haddr == 32'h0;
	wire wm = wr && i_haddr == 32'h8;
	wire wd = wr && i_haddr == 32'h10;
	wire ws = wr && i_haddr == 32'h20;
	// Data phase follows the address, output lands one edge later
	hys_copy_a: assert property (wc |-> ##3 o_hysteresis_level == $past(i_hwdata[2:1], 2))
		else $error("hysteresis copy wrong");
	low_cur_a: assert property (wc |-> ##3 o_low_current_select == $past(i_hwdata[3], 2))
		else $error("low current copy wrong");
	sel_copy_a: assert property (wm |-> ##3 {o_positive_input_select, o_negative_input_select}
		== $past({i_hwdata[4:3], i_hwdata[1:0]}, 2)) else $error("input select wrong");
	inv_copy_a: assert property (wm |-> ##3 o_invert == $past(i_hwdata[7], 2))
		else $error("invert copy wrong");
	div_copy_a: assert property (wd |-> ##3 o_divider_reference_level == $past(i_hwdata[7:0], 2))
		else $error("divider copy wrong");
	pad_gate_a: assert property (o_output_pad_enable |-> o_cmp_enable)
		else $error("pad on while comparator off");
	pdown_off_a: assert property (ws ##1 i_hwdata[1:0] == 2'h3 |-> ##2 !o_cmp_enable && !o_output_pad_enable)
		else $error("power-down left comparator on");
	irq_hold_a: assert property (!wr ##1 !wr ##1 (!wr && o_irq) |=> o_irq)
		else $error("irq dropped without a write");
endmodule // cmpc_props
bind cmpc_top cmpc_props u_props (.*);

// ### verif/cmpc_core_model.sv
`timescale 1ns/1ps
module cmpc_core_model (
	input wire logic i_enable,
	input wire logic i_level,
	output logic o_raw
);
	// A disabled core parks its output low
	assign o_raw = i_enable & i_level;
endmodule // cmpc_core_model

// ### verif/comparator_control_regs_tb.sv
`timescale 1ns/1ps
module comparator_control_regs_tb
	import cmpc_pkg::*;
;
	logic i_clk, i_rst, i_hsel, i_hwrite, i_hready, i_cmp_raw, lvl;
	logic [31:0] i_haddr, i_hwdata, o_hrdata;
	logic [1:0] i_htrans, o_hysteresis_level, o_positive_input_select, o_negative_input_select;
	logic [2:0] i_hsize;
	logic [7:0] o_divider_reference_level;
	logic o_hreadyout, o_hresp, o_cmp_enable, o_low_current_select, o_invert;
	logic o_output_pad_enable, o_event_level, o_irq;
	int fails, checked, cyc;
	cmpc_top uut (.*);
	cmpc_core_model u_core (.i_enable(o_cmp_enable), .i_level(lvl), .o_raw(i_cmp_raw));
	always #10 i_clk = ~i_clk;
	task end_sim;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		// Tests need about 300 cycles
		if (cyc == 6000) begin
			fails++;
			end_sim;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_haddr <= a;
		i_htrans <= CMPC_HTRANS_NONSEQ;
		i_hwrite <= w;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(o_hrdata, e);
		chk({o_hreadyout, o_hresp}, 32'h2);
	endtask
	task t_reset;
		rd(32'h00, 32'h00);
		rd(32'h08, 32'h00);
		rd(32'h10, 32'hff);
		rd(32'h18, 32'h00);
		rd(32'h1c, 32'h00);
		rd(32'h24, 32'h00);
		$display("t_reset end");
	endtask
	task t_fields;
		wr(32'h00, 32'h0e);
		wr(32'h08, 32'hff);
		wr(32'h10, 32'h5a);
		repeat (3) @(posedge i_clk);
		chk({o_invert, o_positive_input_select, o_negative_input_select}, 32'h1f);
		chk({o_low_current_select, o_hysteresis_level, o_cmp_enable}, 32'he);
		rd(32'h10, 32'h5a);
		rd(32'h08, {24'h0, CMPC_MUX_MASK});
		wr(32'h08, 32'h0a);
		repeat (3) @(posedge i_clk);
		chk({o_invert, o_positive_input_select, o_negative_input_select}, 32'h06);
		$display("t_fields end");
	endtask
	task t_edge;
		int m;
		wr(32'h18, 32'h1);
		for (m = 0; m < 4; m++) begin
			lvl <= 1'b0;
			wr(32'h00, {26'h0, m[1:0], 4'h1});
			wr(32'h1c, 32'h1);
			lvl <= 1'b1;
			repeat (8) @(posedge i_clk);
			wr(32'h1c, 32'h0);
			rd(32'h1c, {27'h0, 1'b1, 3'h0, m == 0 || m == 3});
			chk(o_irq, m == 0 || m == 3);
			wr(32'h1c, 32'h1);
			lvl <= 1'b0;
			repeat (8) @(posedge i_clk);
			rd(32'h1c, {31'h0, m == 0 || m == 2});
			wr(32'h1c, 32'h1);
		end
		lvl <= 1'b1;
		repeat (8) @(posedge i_clk);
		wr(32'h18, 32'h0);
		repeat (3) @(posedge i_clk);
		chk(o_irq, 1'b0);
		wr(32'h18, 32'h1);
		repeat (3) @(posedge i_clk);
		chk(o_irq, 1'b1);
		wr(32'h1c, 32'h1);
		repeat (3) @(posedge i_clk);
		chk(o_irq, 1'b0);
		$display("t_edge end");
	endtask
	task t_inv;
		wr(32'h08, 32'h80);
		repeat (8) @(posedge i_clk);
		rd(32'h1c, 32'h0);
		chk(o_event_level, 1'b0);
		wr(32'h08, 32'h00);
		repeat (8) @(posedge i_clk);
		chk(o_event_level, 1'b1);
		wr(32'h1c, 32'h1);
		$display("t_inv end");
	endtask
	task t_sleep;
		wr(32'h00, 32'h41);
		repeat (3) @(posedge i_clk);
		chk({o_output_pad_enable, o_cmp_enable}, 32'h3);
		wr(32'h20, 32'h2);
		repeat (3) @(posedge i_clk);
		chk({o_output_pad_enable, o_cmp_enable}, 32'h0);
		wr(32'h00, 32'hc1);
		repeat (3) @(posedge i_clk);
		chk({o_output_pad_enable, o_cmp_enable}, 32'h3);
		lvl <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(32'h1c, 32'h10);
		wr(32'h20, 32'h3);
		repeat (3) @(posedge i_clk);
		chk({o_output_pad_enable, o_cmp_enable}, 32'h0);
		$display("t_sleep end");
	endtask
	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_hsel = 1'b1;
		i_hready = 1'b1;
		i_hsize = CMPC_HSIZE_WORD;
		i_haddr = 32'h0;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_hwdata = 32'h0;
		lvl = 1'b0;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset;
		t_fields;
		t_edge;
		t_inv;
		t_sleep;
		end_sim;
	end
endmodule // comparator_control_regs_tb
